// ---- logic/wat_pkg.sv ----
package wat_pkg;
    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0] WAT_CTRL_OFS = 8'h00;
    localparam logic [7:0] WAT_TDIV_OFS = 8'h04;
    localparam logic [7:0] WAT_POST_OFS = 8'h08;
    localparam logic [7:0] WAT_STAT_OFS = 8'h0c;
    localparam logic [7:0] WAT_MADR_OFS = 8'h10;
    localparam logic [7:0] WAT_MDAT_OFS = 8'h14;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_HALT_BIT = 1;
    localparam int CTRL_SRC_LSB = 2;
    localparam int CTRL_TMODE_LSB = 4;
    localparam logic [31:0] TDIV_RST = 32'h000186a0;
    localparam logic [9:0] POST_RST = 10'h200;
    // ****************************************************************
    // timing and sweep constants
    // ****************************************************************
    localparam int CLK_HZ = 25000000;
    localparam int SAMPLE_HZ = 400000;
    localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
    localparam int CCD_DELAY = 455;
    localparam int SPD_STD = 100;
    localparam int SPD_ERD = 80;
    localparam int ERD_REC = 820;
    localparam logic [31:0] ROLL_MIN_US = 32'd100000;
    localparam logic [31:0] RD_MIN_US = 32'd500;
    localparam logic [31:0] ERD_MIN_US = 32'd2;
    localparam logic [31:0] DEC_US = 32'd1000000 / SPD_STD * SAMPLE_HZ / 32'd1000000;
    typedef enum {roll_mode, realtime_mode, extended_realtime_mode, equivalent_time_mode} wat_mode_e;
    typedef enum {src_ch1, src_ch2, src_line, src_ext} wat_src_e;
    typedef enum {st_idle, st_arm, st_delay, st_post, st_readout, st_hold} wat_state_e;
    typedef struct packed {
        logic we;
        logic [10:0] addr;
        logic [7:0] data;
    } wat_wr_s;
endpackage : wat_pkg

// ---- logic/wat_timebase.sv ----
// Summary of operation
// [R1] sweep setting picks mode and samples/division
// [R2] roll mode clocks shift register at 400 kHz
// [R3] roll stores one sample per decimation ratio
// [R4] roll write address wraps 1023 to 0
// [R5] roll display start follows newest sample
// [R6] roll acquires untriggered in all trigger modes
// [R7] halt-after-trigger stops roll after set count
// [R8] real-time stores until record full, then re-arms
// [R9] real-time compensates 455-sample shift delay
// [R10] post-trigger count sets stored signal portion
// [R11] real-time alternates between two 1K blocks
// [R12] extended mode fast sampling until post count
// [R13] extended mode reads held samples at 400 kHz
// [R14] extended mode restarts into other block
// [R15] each sample clock shifts register one cell
// [R16] trigger source chosen from four inputs
// [R17] display reads granted in timed memory slots
// [R18] processor reads and writes waveform memory
// [R19] halves sample together, alternate in extended
// [R20] decimation ratio equals 400 kHz over store rate
// [R21] 10-bit write counter, block toggles per record
//
// The placing of the registers and strobed register access were decided locally.
module wat_timebase
    import wat_pkg::*;
#(
    parameter int MEM_AW = 10,
    parameter int DATA_W = 8
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic input_channel_one,
    input wire logic input_channel_two,
    input wire logic trig_line,
    input wire logic trig_ext,
    input wire logic [DATA_W-1:0] adc_data,
    output logic ccd_clk_a,
    output logic ccd_clk_b,
    output logic adc_start,
    output logic [MEM_AW:0] disp_addr,
    output logic [DATA_W-1:0] disp_data,
    output logic disp_valid
);
    // ****************************************************************
    // parameter checks
    // ****************************************************************
    generate
        if (MEM_AW != 10 || DATA_W != 8) begin : g_bad
            $error("wat_timebase supports only 1K blocks of 8-bit samples");
        end
    endgenerate

    function automatic wat_mode_e mode_of(input logic [31:0] us);
        if (us >= ROLL_MIN_US) mode_of = roll_mode;
        else if (us >= RD_MIN_US) mode_of = realtime_mode;
        else if (us >= ERD_MIN_US) mode_of = extended_realtime_mode;
        else mode_of = equivalent_time_mode;
    endfunction : mode_of

    function automatic logic [31:0] fast_cyc(input logic [31:0] us);
        logic [31:0] c;
        c = us * 32'd25 / 32'(SPD_ERD);
        fast_cyc = (c == 32'd0) ? 32'd1 : c;
    endfunction : fast_cyc

    // ****************************************************************
    // registers
    // ****************************************************************
    logic run_r, halt_r;
    logic [1:0] src_r, tmode_r;
    logic [31:0] tdiv_r;
    logic [9:0] post_r;
    logic [10:0] madr_r;
    logic [31:0] rdata_r;
    logic cpu_wpend_r;
    logic [7:0] cpu_wdata_r;
    logic [DATA_W-1:0] wmem [0:2047];
    wat_mode_e mode;
    wat_state_e state_r;
    logic blk_r;
    logic [MEM_AW-1:0] waddr_r;
    logic [31:0] ratio;

    assign mode = mode_of(tdiv_r); // [R1]
    assign ratio = (tdiv_r / 32'd250 == 32'd0) ? 32'd1 : tdiv_r / 32'd250; // [R20]

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            run_r <= 1'b0;
            halt_r <= 1'b0;
            src_r <= 2'h0;
            tmode_r <= 2'h0;
            tdiv_r <= TDIV_RST;
            post_r <= POST_RST;
            madr_r <= 11'h000;
        end else if (reg_wr) begin
            case (reg_addr)
                WAT_CTRL_OFS: begin
                    run_r <= reg_wdata[CTRL_RUN_BIT];
                    halt_r <= reg_wdata[CTRL_HALT_BIT];
                    src_r <= reg_wdata[CTRL_SRC_LSB +: 2];
                    tmode_r <= reg_wdata[CTRL_TMODE_LSB +: 2];
                end
                WAT_TDIV_OFS: tdiv_r <= reg_wdata;
                WAT_POST_OFS: post_r <= reg_wdata[9:0];
                WAT_MADR_OFS: madr_r <= reg_wdata[10:0];
                default: ;
            endcase
        end else if (reg_rd && reg_addr == WAT_MDAT_OFS) begin
            madr_r <= madr_r + 11'h001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rdata_r <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                WAT_CTRL_OFS: rdata_r <= {26'h0, tmode_r, src_r, halt_r, run_r};
                WAT_TDIV_OFS: rdata_r <= tdiv_r;
                WAT_POST_OFS: rdata_r <= {22'h0, post_r};
                WAT_STAT_OFS: rdata_r <= {12'h0, waddr_r, 1'b0, blk_r, 3'h0,
                    3'(state_r), 2'(mode)};
                WAT_MADR_OFS: rdata_r <= {21'h0, madr_r};
                WAT_MDAT_OFS: rdata_r <= {24'h0, wmem[madr_r]}; // [R18]
                default: rdata_r <= 32'h00000000;
            endcase
        end else begin
            rdata_r <= 32'h00000000;
        end
    end
    assign reg_rdata = rdata_r;

    // ****************************************************************
    // trigger gate
    // ****************************************************************
    logic trig_lvl, trig_d_r, trig_ev;
    always_comb begin
        case (wat_src_e'(src_r)) // [R16]
            src_ch1: trig_lvl = input_channel_one;
            src_ch2: trig_lvl = input_channel_two;
            src_line: trig_lvl = trig_line;
            src_ext: trig_lvl = trig_ext;
            default: trig_lvl = 1'b0;
        endcase
    end
    always_ff @(posedge ref_clk) begin
        if (!resetn) trig_d_r <= 1'b0;
        else trig_d_r <= trig_lvl;
    end
    assign trig_ev = trig_lvl && !trig_d_r;

    // ****************************************************************
    // sample clocking
    // ****************************************************************
    logic [31:0] tick_cnt_r, dec_cnt_r;
    logic tick, fast_phase_r, ccd_a_r, ccd_b_r, adc_r;
    logic fast_mode;
    assign fast_mode = (mode == extended_realtime_mode) && (state_r != st_readout);
    assign tick = (tick_cnt_r == 32'd0);
    always_ff @(posedge ref_clk) begin
        if (!resetn) tick_cnt_r <= 32'd0;
        else if (tick) tick_cnt_r <= fast_mode ? fast_cyc(tdiv_r) - 32'd1
            : 32'(SAMPLE_CYC - 1); // [R2] [R12] [R13]
        else tick_cnt_r <= tick_cnt_r - 32'd1;
    end

    logic sampling;
    assign sampling = run_r && (state_r != st_hold) && (state_r != st_idle)
        && (mode != equivalent_time_mode);
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ccd_a_r <= 1'b0;
            ccd_b_r <= 1'b0;
            adc_r <= 1'b0;
            fast_phase_r <= 1'b0;
        end else begin
            ccd_a_r <= 1'b0;
            ccd_b_r <= 1'b0;
            adc_r <= 1'b0;
            if (tick && sampling) begin
                if (fast_mode) begin // [R19]
                    ccd_a_r <= !fast_phase_r;
                    ccd_b_r <= fast_phase_r;
                    fast_phase_r <= !fast_phase_r;
                end else begin
                    ccd_a_r <= 1'b1; // [R15]
                    ccd_b_r <= 1'b1;
                    adc_r <= 1'b1;
                end
            end
        end
    end
    assign ccd_clk_a = ccd_a_r;
    assign ccd_clk_b = ccd_b_r;
    assign adc_start = adc_r;

    // ****************************************************************
    // acquisition control
    // ****************************************************************
    logic [31:0] cnt_r;
    logic store;
    wat_wr_s acq_r;
    logic [1:0] slot_r;
    assign store = tick && sampling && !fast_mode
        && (state_r == st_readout || dec_cnt_r == 32'd0); // [R3] [R8]

    always_ff @(posedge ref_clk) begin
        if (!resetn) dec_cnt_r <= 32'd0;
        else if (tick && sampling && !fast_mode)
            dec_cnt_r <= (dec_cnt_r == 32'd0) ? ratio - 32'd1 : dec_cnt_r - 32'd1; // [R20]
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state_r <= st_idle;
            cnt_r <= 32'd0;
            blk_r <= 1'b0;
            waddr_r <= '0;
        end else if (!run_r) begin
            state_r <= st_idle;
        end else begin
            if (store) waddr_r <= waddr_r + 10'h001; // [R4] [R21]
            case (state_r)
                st_idle: begin
                    state_r <= st_arm;
                    waddr_r <= '0;
                end
                st_arm: begin
                    if (trig_ev && (mode != roll_mode || halt_r)) begin // [R6] [R7]
                        state_r <= (mode == realtime_mode) ? st_delay : st_post;
                        cnt_r <= (mode == realtime_mode) ? 32'(CCD_DELAY) - 32'd1
                            : {22'h0, post_r}; // [R9] [R10]
                    end
                end
                st_delay: begin
                    if (tick) begin
                        if (cnt_r == 32'd0) begin
                            state_r <= st_post;
                            cnt_r <= {22'h0, post_r};
                        end else cnt_r <= cnt_r - 32'd1; // [R9]
                    end
                end
                st_post: begin
                    if (mode == extended_realtime_mode) begin
                        if (tick) begin
                            if (cnt_r == 32'd0) begin // [R12]
                                state_r <= st_readout;
                                cnt_r <= 32'(ERD_REC);
                                waddr_r <= '0;
                            end else cnt_r <= cnt_r - 32'd1;
                        end
                    end else if (store) begin
                        if (cnt_r == 32'd0) begin
                            state_r <= (mode == roll_mode) ? st_hold : st_arm; // [R7] [R8]
                            blk_r <= (mode == realtime_mode) ? !blk_r : blk_r; // [R11]
                        end else cnt_r <= cnt_r - 32'd1; // [R10]
                    end
                end
                st_readout: begin
                    if (store) begin // [R13]
                        if (cnt_r == 32'd1) begin
                            state_r <= st_arm; // [R14]
                            blk_r <= !blk_r; // [R21]
                        end
                        cnt_r <= cnt_r - 32'd1;
                    end
                end
                st_hold: ;
                default: state_r <= st_idle;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) acq_r <= '0;
        else if (store) acq_r <= '{we: 1'b1, addr: {blk_r, waddr_r}, data: adc_data};
        else if (slot_r == 2'd0) acq_r.we <= 1'b0;
    end

    // ****************************************************************
    // memory slots and display scan
    // ****************************************************************
    logic [MEM_AW-1:0] scan_r;
    logic [MEM_AW:0] daddr_r;
    logic [DATA_W-1:0] ddata_r;
    logic dvalid_r;
    always_ff @(posedge ref_clk) begin
        if (!resetn) slot_r <= 2'd0;
        else slot_r <= slot_r + 2'd1; // [R17]
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            cpu_wpend_r <= 1'b0;
            cpu_wdata_r <= 8'h00;
        end else if (reg_wr && reg_addr == WAT_MDAT_OFS) begin
            cpu_wpend_r <= 1'b1;
            cpu_wdata_r <= reg_wdata[7:0];
        end else if (slot_r == 2'd2) begin
            cpu_wpend_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (slot_r == 2'd0 && acq_r.we) wmem[acq_r.addr] <= acq_r.data;
        else if (slot_r == 2'd2 && cpu_wpend_r) wmem[madr_r] <= cpu_wdata_r; // [R18]
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            scan_r <= '0;
            daddr_r <= '0;
            ddata_r <= '0;
            dvalid_r <= 1'b0;
        end else begin
            dvalid_r <= 1'b0;
            if (slot_r[0]) begin // [R17]
                scan_r <= scan_r + 10'h001;
                dvalid_r <= 1'b1;
                if (mode == roll_mode) begin
                    daddr_r <= {blk_r, waddr_r + scan_r}; // [R5]
                    ddata_r <= wmem[{blk_r, waddr_r + scan_r}];
                end else begin
                    daddr_r <= {!blk_r, scan_r}; // [R11]
                    ddata_r <= wmem[{!blk_r, scan_r}];
                end
            end
        end
    end
    assign disp_addr = daddr_r;
    assign disp_data = ddata_r;
    assign disp_valid = dvalid_r;

    // ****************************************************************
    // assertions
    // ****************************************************************
    a_mode_roll: assert property (@(posedge ref_clk) disable iff (!resetn)
        tdiv_r >= ROLL_MIN_US |-> mode == roll_mode) // [R1]
        else $error("roll mode not chosen for slow sweep");
    // cycles since the last sample clock, saturating
    logic [7:0] gap_r;
    always_ff @(posedge ref_clk) begin
        if (!resetn) gap_r <= 8'hff;
        else if (ccd_a_r) gap_r <= 8'h00;
        else if (gap_r != 8'hff) gap_r <= gap_r + 8'h01;
    end
    a_roll_rate: assert property (@(posedge ref_clk) disable iff (!resetn)
        ccd_a_r && mode == roll_mode |-> gap_r >= 8'(SAMPLE_CYC - 1)) // [R2]
        else $error("roll sample clock faster than 400 kHz");
    a_addr_wrap: assert property (@(posedge ref_clk) disable iff (!resetn)
        store && waddr_r == 10'h3ff && state_r != st_idle |=> waddr_r == 10'h000) // [R4]
        else $error("write address did not wrap");
    a_roll_free: assert property (@(posedge ref_clk) disable iff (!resetn)
        mode == roll_mode && !halt_r && state_r == st_arm |=> state_r != st_post) // [R6]
        else $error("roll left free run without halt");
    a_hold_keep: assert property (@(posedge ref_clk) disable iff (!resetn)
        state_r == st_hold && run_r |=> !store) // [R7]
        else $error("store while holding");
    a_rt_delay: assert property (@(posedge ref_clk) disable iff (!resetn)
        state_r == st_arm && mode == realtime_mode && trig_ev && run_r
        |=> state_r == st_delay && cnt_r == 32'd454) // [R9]
        else $error("delay compensation not loaded");
    a_erd_alt: assert property (@(posedge ref_clk) disable iff (!resetn)
        fast_mode |-> !(ccd_a_r && ccd_b_r)) // [R19]
        else $error("extended halves clocked together");
    a_blk_flip: assert property (@(posedge ref_clk) disable iff (!resetn)
        state_r == st_readout && store && cnt_r == 32'd1 && run_r
        |=> blk_r != $past(blk_r)) // [R14]
        else $error("block select did not toggle");
    a_disp_slot: assert property (@(posedge ref_clk) disable iff (!resetn)
        dvalid_r |-> $past(slot_r[0])) // [R17]
        else $error("display read outside its slot");
endmodule : wat_timebase

// ---- verif/wat_ccd_model.sv ----
module wat_ccd_model #(
    parameter int DEPTH = 455
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic ccd_clk_a,
    input wire logic ccd_clk_b,
    output logic [7:0] adc_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cell_r [DEPTH];
    logic [7:0] level_r;
    // ****************************************************************
    // analog shift register and converter
    // ****************************************************************
    // each sampling clock takes a new level into the first cell and
    // moves every held sample one cell toward the converter
    always @(posedge ref_clk) begin
        if (!resetn) begin
            level_r <= 8'h00;
            adc_data <= 8'h00;
            foreach (cell_r[i]) cell_r[i] <= 8'h00;
        end else if (ccd_clk_a || ccd_clk_b) begin
            level_r <= level_r + 8'h35;
            cell_r[0] <= level_r;
            for (int i = 1; i < DEPTH; i++) cell_r[i] <= cell_r[i-1];
            adc_data <= cell_r[DEPTH-1];
        end
    end
endmodule : wat_ccd_model

// ---- verif/waveform_acquisition_timebase_tb.sv ----
module waveform_acquisition_timebase_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import wat_pkg::*;
    localparam int TMO = 80000;
    logic ref_clk;
    logic resetn;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic [3:0] trig_in;
    logic [7:0] adc_data;
    logic ccd_clk_a;
    logic ccd_clk_b;
    logic adc_start;
    logic [10:0] disp_addr;
    logic [7:0] disp_data;
    logic disp_valid;
    logic [31:0] rng_r;
    logic [31:0] rd_v;
    logic [9:0] w0;
    logic b0;
    logic [7:0] mem_m [2048];
    int tdiv_tab [6] = '{100000, 99999, 500, 499, 2, 1};
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;
    int t0, k, na, nb, nab, ns;
    wat_timebase u_wat_timebase (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .input_channel_one(trig_in[0]), .input_channel_two(trig_in[1]),
        .trig_line(trig_in[2]), .trig_ext(trig_in[3]), .adc_data(adc_data),
        .ccd_clk_a(ccd_clk_a), .ccd_clk_b(ccd_clk_b), .adc_start(adc_start),
        .disp_addr(disp_addr), .disp_data(disp_data), .disp_valid(disp_valid));
    wat_ccd_model u_wat_ccd_model (.ref_clk(ref_clk), .resetn(resetn), .ccd_clk_a(ccd_clk_a),
        .ccd_clk_b(ccd_clk_b), .adc_data(adc_data));
    // ****************************************************************
    // reference model and helpers
    // ****************************************************************
    function automatic int mode_of(input int us);
        if (us >= 100000) return 0;
        if (us >= 500) return 1;
        if (us >= 2) return 2;
        return 3;
    endfunction : mode_of
    function automatic int dec_of(input int us);
        longint r;
        r = longint'(us) * SAMPLE_HZ / (SPD_STD * 1000000);
        return (r < 1) ? 1 : int'(r);
    endfunction : dec_of
    function logic [31:0] next_rand();
        rng_r = rng_r ^ (rng_r << 13);
        rng_r = rng_r ^ (rng_r >> 17);
        rng_r = rng_r ^ (rng_r << 5);
        return rng_r;
    endfunction : next_rand
    task close_out;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task ticks(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            while (ccd_clk_a !== 1'b1) @(posedge ref_clk);
        end
    endtask : ticks
    task pulse(input int i);
        @(posedge ref_clk);
        trig_in[i] <= 1'b1;
        repeat (3) @(posedge ref_clk);
        trig_in[i] <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask : pulse
    // ****************************************************************
    // clock, timeout and test sequence
    // ****************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == TMO) begin
            n_mismatch++;
            close_out();
        end
    end
    initial begin
        rng_r = 32'h7b4b;
        resetn = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        trig_in = 4'h0;
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        rd(WAT_TDIV_OFS, rd_v);
        chk("tdiv reset", TDIV_RST, rd_v);
        rd(WAT_POST_OFS, rd_v);
        chk("post reset", {22'h0, POST_RST}, rd_v);
        rd(8'h3c, rd_v);
        chk("unmapped", 32'h0, rd_v);
        foreach (tdiv_tab[i]) begin
            wr(WAT_TDIV_OFS, tdiv_tab[i]);
            rd(WAT_STAT_OFS, rd_v);
            chk("mode", 32'(mode_of(tdiv_tab[i])), {30'h0, rd_v[1:0]});
        end
        $display("test reset and modes done");
        wr(WAT_TDIV_OFS, 32'd100000);
        wr(WAT_CTRL_OFS, 32'h21);
        ticks(1);
        t0 = cyc;
        ticks(1);
        chk("tick period", SAMPLE_CYC, cyc - t0);
        chk("roll clocks", 32'h7, {29'h0, ccd_clk_a, ccd_clk_b, adc_start});
        repeat (20) @(posedge ref_clk);
        rd(WAT_STAT_OFS, rd_v);
        w0 = rd_v[19:10];
        ticks(dec_of(100000));
        repeat (20) @(posedge ref_clk);
        rd(WAT_STAT_OFS, rd_v);
        chk("roll store", {22'h0, w0 + 10'h1}, {22'h0, rd_v[19:10]});
        k = 0;
        while (disp_valid !== 1'b1 && k < 8) begin
            @(posedge ref_clk);
            k++;
        end
        chk("display slot", 32'h1, {31'h0, disp_valid});
        $display("test roll done");
        wr(WAT_CTRL_OFS, 32'h0);
        wr(WAT_TDIV_OFS, 32'd500);
        wr(WAT_POST_OFS, 32'd3);
        wr(WAT_CTRL_OFS, 32'h1);
        rd(WAT_STAT_OFS, rd_v);
        b0 = rd_v[8];
        chk("armed", 32'h1, {29'h0, rd_v[4:2]});
        pulse(0);
        ticks(CCD_DELAY - 15);
        rd(WAT_STAT_OFS, rd_v);
        chk("block held", {31'h0, b0}, {31'h0, rd_v[8]});
        ticks(15 + 4 * dec_of(500) + 10);
        rd(WAT_STAT_OFS, rd_v);
        chk("block flip", {31'h0, ~b0}, {31'h0, rd_v[8]});
        k = 0;
        while (disp_valid !== 1'b1 && k < 8) begin
            @(posedge ref_clk);
            k++;
        end
        chk("display block", {31'h0, b0}, {31'h0, disp_addr[10]});
        $display("test realtime done");
        for (int s = 0; s < 4; s++) begin
            wr(WAT_CTRL_OFS, 32'h0);
            wr(WAT_CTRL_OFS, 32'h1 | 32'(s << 2));
            pulse((s + 1) % 4);
            rd(WAT_STAT_OFS, rd_v);
            chk("wrong source", 32'h1, {29'h0, rd_v[4:2]});
            pulse(s);
            rd(WAT_STAT_OFS, rd_v);
            chk("right source", 32'h2, {29'h0, rd_v[4:2]});
        end
        $display("test trigger source done");
        wr(WAT_CTRL_OFS, 32'h0);
        wr(WAT_TDIV_OFS, 32'd2);
        wr(WAT_CTRL_OFS, 32'h1);
        na = 0;
        nb = 0;
        nab = 0;
        ns = 0;
        repeat (300) begin
            @(posedge ref_clk);
            na += ccd_clk_a;
            nb += ccd_clk_b;
            nab += ccd_clk_a & ccd_clk_b;
            ns += adc_start;
        end
        chk("halves together", 32'h0, nab);
        chk("halves active", 32'h1, {31'h0, na > 0 && nb > 0});
        chk("fast-in convert", 32'h0, ns);
        $display("test extended done");
        wr(WAT_CTRL_OFS, 32'h0);
        for (int a = 11'h3ff; a <= 11'h400; a++) begin
            rd_v = next_rand();
            mem_m[a] = rd_v[7:0];
            wr(WAT_MADR_OFS, 32'(a));
            wr(WAT_MDAT_OFS, {24'h0, rd_v[7:0]});
            repeat (4) @(posedge ref_clk);
        end
        wr(WAT_MADR_OFS, 32'h3ff);
        rd(WAT_MDAT_OFS, rd_v);
        chk("mem lo", {24'h0, mem_m[11'h3ff]}, {24'h0, rd_v[7:0]});
        rd(WAT_MDAT_OFS, rd_v);
        chk("mem hi", {24'h0, mem_m[11'h400]}, {24'h0, rd_v[7:0]});
        k = 0;
        while (!(disp_valid === 1'b1 && disp_addr === 11'h3ff) && k < 2100) begin
            @(posedge ref_clk);
            k++;
        end
        chk("display addr", 32'h3ff, {21'h0, disp_addr});
        chk("display data", {24'h0, mem_m[11'h3ff]}, {24'h0, disp_data});
        $display("test memory done");
        close_out();
    end
endmodule : waveform_acquisition_timebase_tb
